// [rtl/spd_setter.sv]
// Speed preset selection and remote up/down frequency setter
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "spd_consts.svh"
module spd_setter #(
    parameter int MINUTE_CYC = `SPD_SAVE_PERIOD_S * `SPD_CLK_HZ
) (
    input wire logic clk, // System clock, 20 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic [3:0] avs_address, // Word address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Low for one cycle to answer
    input wire logic high_select_or_up_input, // Pin
    input wire logic middle_select_or_down_input, // Pin
    input wire logic low_select_or_clear_input, // Pin
    input wire logic forward_start_input, // Pin
    input wire logic reverse_start_input, // Pin
    input wire logic second_function_select, // Pin
    input wire logic aux_supply_input, // Pin, high on auxiliary supply
    input wire logic jog_active, // Jog in progress
    input wire logic local_operator_panel, // Panel operation mode
    input wire spd_pkg::spd_freq_t network_freq, // Network command
    input wire spd_pkg::spd_freq_t panel_freq, // Panel frequency
    input wire spd_pkg::spd_freq_t nv_restore_data, // Stored amount
    input wire logic nv_wr_ack, // Store done pulse
    output logic nv_wr_req, // Store request, held until ack
    output spd_pkg::spd_freq_t nv_wr_data, // Amount to store
    output spd_pkg::spd_freq_t freq_cmd, // Resulting command
    output logic remote_active, // Remote mode in force
    output logic second_set_active // Alternate set selected
);
    import spd_pkg::*;

    localparam int RAMP_TICK_CYC = `SPD_RAMP_TICK_CYC;

    // Synchronisers: three stages, change accepted once stages 2 and 3 agree
    logic [6:0] pin_raw, s1_q, s2_q, s3_q, filt_q, prev_q;
    assign pin_raw = {aux_supply_input, second_function_select,
                      reverse_start_input, forward_start_input,
                      low_select_or_clear_input, middle_select_or_down_input,
                      high_select_or_up_input};
    generate
        for (genvar i = 0; i < 7; i++) begin : g_sync
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    filt_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= pin_raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        filt_q[i] <= s3_q[i];
                    end
                    prev_q[i] <= filt_q[i];
                end
            end
        end
    endgenerate

    logic sel_h, sel_m, sel_l, fwd, rev, second, aux, running;
    assign sel_h = filt_q[0];
    assign sel_m = filt_q[1];
    assign sel_l = filt_q[2];
    assign fwd = filt_q[3];
    assign rev = filt_q[4];
    assign second = filt_q[5];
    assign aux = filt_q[6];
    assign running = fwd | rev;

    // Configuration registers
    spd_mode_t mode_q;
    spd_freq_t acc1_q, dec1_q, acc2_q, dec2_q, maxf_q;
    logic [1:0] wprot_q;
    spd_freq_t adj_q, saved_q, data_a, data_b;
    logic restored_q;
    logic remote;
    assign remote = (mode_q != SPD_MODE_PRESET);

    // Bus slave: one wait cycle for the memory; writes land on the answer
    spd_bus_st_t bus_q;
    logic bus_req, bus_do_wr, cfg_ok, is_preset;
    assign bus_req = avs_read | avs_write;
    assign is_preset = (avs_address <= `SPD_IDX_PRESET_LAST);
    assign bus_do_wr = (bus_q == SPD_BUS_ACK) && avs_write;
    // Presets and the protection word bypass the protection; other settings only while stopped or with SPD_WPROT_RUN_OK
    assign cfg_ok = !running || (wprot_q == `SPD_WPROT_RUN_OK);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= SPD_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_q)
                SPD_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_q <= SPD_BUS_WAIT;
                    end
                end
                SPD_BUS_WAIT: begin
                    bus_q <= SPD_BUS_ACK;
                    avs_waitrequest <= 1'b0;
                end
                SPD_BUS_ACK: begin
                    bus_q <= SPD_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_q <= SPD_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Writable settings
    logic mode_wr;
    assign mode_wr = bus_do_wr && cfg_ok && avs_address == `SPD_IDX_MODE;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= spd_mode_t'(`SPD_RST_MODE);
            acc1_q <= `SPD_RST_TIME;
            dec1_q <= `SPD_RST_TIME;
            acc2_q <= `SPD_RST_TIME;
            dec2_q <= `SPD_RST_TIME;
            maxf_q <= `SPD_RST_MAXF;
            wprot_q <= `SPD_RST_WPROT;
        end else if (bus_do_wr) begin
            if (avs_address == `SPD_IDX_WPROT) begin
                wprot_q <= avs_writedata[1:0];
            end
            if (cfg_ok) begin
                case (avs_address)
                    `SPD_IDX_MODE: mode_q <= spd_mode_t'(avs_writedata[1:0]);
                    `SPD_IDX_ACC1: acc1_q <= avs_writedata[15:0];
                    `SPD_IDX_DEC1: dec1_q <= avs_writedata[15:0];
                    `SPD_IDX_ACC2: acc2_q <= avs_writedata[15:0];
                    `SPD_IDX_DEC2: dec2_q <= avs_writedata[15:0];
                    `SPD_IDX_MAXF: maxf_q <= avs_writedata[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Preset slot decode: combinations first, else lowest-ranked input
    function automatic spd_slot_t combo_slot(input logic h, m, l);
        case ({h, m, l})
            3'b100: combo_slot = `SPD_SLOT_HIGH;
            3'b010: combo_slot = `SPD_SLOT_MID;
            3'b001: combo_slot = `SPD_SLOT_LOW;
            3'b011: combo_slot = `SPD_SLOT_S4;
            3'b101: combo_slot = `SPD_SLOT_S5;
            3'b110: combo_slot = `SPD_SLOT_S6;
            3'b111: combo_slot = `SPD_SLOT_S7;
            default: combo_slot = `SPD_SLOT_HIGH;
        endcase
    endfunction

    spd_slot_t slot_a, slot_b;
    assign slot_a = combo_slot(sel_h, sel_m, sel_l);
    assign slot_b = (bus_q != SPD_BUS_ACK && bus_req && is_preset) ?
                    avs_address[2:0] :
                    (sel_l ? `SPD_SLOT_LOW :
                     (sel_m ? `SPD_SLOT_MID : `SPD_SLOT_HIGH));

    spd_preset_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(bus_do_wr && is_preset),
        .wr_slot(avs_address[2:0]),
        .wr_data(avs_writedata[15:0]),
        .rd_a_slot(slot_a),
        .rd_b_slot(slot_b),
        .rd_a_data(data_a),
        .rd_b_data(data_b)
    );

    // Ramp rate: second times when selected, else the longer of the two
    logic up, down, ramping, tick;
    spd_freq_t time_sel, step_q;
    logic [11:0] presc_q;
    assign up = sel_h && !sel_m && remote && !jog_active;
    assign down = sel_m && !sel_h && remote && !jog_active;
    assign ramping = up | down;
    assign tick = (presc_q == 12'(RAMP_TICK_CYC - 1));
    always_comb begin
        if (second) begin
            time_sel = up ? acc2_q : dec2_q;
        end else if (up) begin
            time_sel = (acc1_q > acc2_q) ? acc1_q : acc2_q;
        end else begin
            time_sel = (dec1_q > dec2_q) ? dec1_q : dec2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_q <= 12'h000;
            step_q <= 16'h0000;
        end else if (!ramping) begin
            presc_q <= 12'h000;
            step_q <= 16'h0000;
        end else if (tick) begin
            presc_q <= 12'h000;
            step_q <= (step_q >= time_sel) ? 16'h0000 : step_q + 16'h0001;
        end else begin
            presc_q <= presc_q + 12'h001;
        end
    end

    // Remote amount
    logic step_now, start_fall, clr_now;
    assign step_now = ramping && tick && (step_q >= time_sel);
    assign start_fall = (prev_q[3] & !fwd) | (prev_q[4] & !rev);
    assign clr_now = remote && !jog_active && sel_l;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adj_q <= 16'h0000;
        end else if (clr_now) begin
            adj_q <= 16'h0000;
        end else if (mode_q == SPD_MODE_REM_STARTCLR && start_fall) begin
            adj_q <= 16'h0000;
        end else if (mode_wr && avs_writedata[1:0] == SPD_MODE_REM_STORE) begin
            adj_q <= saved_q;
        end else if (adj_q > maxf_q) begin
            adj_q <= maxf_q;
        end else if (step_now && up && adj_q < maxf_q) begin
            adj_q <= adj_q + 16'h0001;
        end else if (step_now && down && adj_q != 16'h0000) begin
            adj_q <= adj_q - 16'h0001;
        end
    end

    // Storage: minute checks armed when the up and down inputs both change in one cycle
    logic armed_q, minute_tick, save_trig, pending_q;
    logic [30:0] minute_q;
    assign minute_tick = armed_q && (minute_q == 31'(MINUTE_CYC - 1));
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
            minute_q <= 31'h0000_0000;
        end else begin
            if (remote && !jog_active &&
                (sel_h != prev_q[0]) && (sel_m != prev_q[1])) begin
                armed_q <= 1'b1;
            end else if (mode_q != SPD_MODE_REM_STORE) begin
                armed_q <= 1'b0;
            end
            minute_q <= (!armed_q || minute_tick) ? 31'h0000_0000 :
                        minute_q + 31'h0000_0001;
        end
    end

    // A cleared amount only reaches storage at the next save point
    assign save_trig = (mode_q == SPD_MODE_REM_STORE) &&
        (start_fall ||
         (minute_tick && adj_q != saved_q) ||
         (aux && !prev_q[6] && running));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restored_q <= 1'b0;
            saved_q <= 16'h0000;
            pending_q <= 1'b0;
            nv_wr_req <= 1'b0;
            nv_wr_data <= 16'h0000;
        end else if (!restored_q) begin
            restored_q <= 1'b1;
            saved_q <= nv_restore_data;
        end else begin
            // A trigger while a store runs queues one more; set wins
            if (save_trig) begin
                pending_q <= 1'b1;
            end else if (!nv_wr_req) begin
                pending_q <= 1'b0;
            end
            if (!nv_wr_req && pending_q) begin
                nv_wr_req <= 1'b1;
                nv_wr_data <= adj_q;
                saved_q <= adj_q;
            end else if (nv_wr_ack) begin
                nv_wr_req <= 1'b0;
            end
        end
    end

    // Command output, in preset mode held while the bus borrows memory port B
    spd_freq_t base, sum;
    assign base = local_operator_panel ? panel_freq : network_freq;
    assign sum = base + adj_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_cmd <= 16'h0000;
        end else if (remote) begin
            freq_cmd <= sum;
        end else if (bus_q != SPD_BUS_IDLE || bus_req) begin
            freq_cmd <= freq_cmd;
        end else if (!(sel_h | sel_m | sel_l)) begin
            freq_cmd <= base;
        end else if ((sel_h + sel_m + sel_l) == 2'd1 ||
                     data_a != `SPD_NOT_SELECTED) begin
            freq_cmd <= data_a;
        end else begin
            freq_cmd <= data_b;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remote_active <= 1'b0;
            second_set_active <= 1'b0;
        end else begin
            remote_active <= remote;
            second_set_active <= second;
        end
    end

    // Read data are captured as the wait cycle ends
    logic [31:0] status;
    always_comb begin
        status = 32'h0000_0000;
        status[15:0] = adj_q;
        status[`SPD_ST_MODE_LSB +: 2] = mode_q;
        status[`SPD_ST_SECOND] = second;
        status[`SPD_ST_NV_PEND] = pending_q | nv_wr_req;
        status[`SPD_ST_JOG] = jog_active;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_q == SPD_BUS_WAIT) begin
            case (avs_address)
                `SPD_IDX_MODE: avs_readdata <= {30'h0000_0000, mode_q};
                `SPD_IDX_ACC1: avs_readdata <= {16'h0000, acc1_q};
                `SPD_IDX_DEC1: avs_readdata <= {16'h0000, dec1_q};
                `SPD_IDX_ACC2: avs_readdata <= {16'h0000, acc2_q};
                `SPD_IDX_DEC2: avs_readdata <= {16'h0000, dec2_q};
                `SPD_IDX_MAXF: avs_readdata <= {16'h0000, maxf_q};
                `SPD_IDX_WPROT: avs_readdata <= {30'h0000_0000, wprot_q};
                `SPD_IDX_STATUS: avs_readdata <= status;
                `SPD_IDX_FREQ: avs_readdata <= {16'h0000, freq_cmd};
                default: avs_readdata <= {16'h0000, data_b};
            endcase
        end
    end
endmodule // spd_setter

// [rtl/spd_consts.svh]
// Register indices, reset values and timing counts of the speed setter
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// Word indices on the register bus; byte address is four times the index
`define SPD_IDX_PRESET_LAST 4'h6
`define SPD_IDX_MODE 4'h7
`define SPD_IDX_ACC1 4'h8
`define SPD_IDX_DEC1 4'h9
`define SPD_IDX_ACC2 4'hA
`define SPD_IDX_DEC2 4'hB
`define SPD_IDX_MAXF 4'hC
`define SPD_IDX_WPROT 4'hD
`define SPD_IDX_STATUS 4'hE
`define SPD_IDX_FREQ 4'hF

// Memory slots: 0 high, 1 middle, 2 low, 3..6 speeds four to seven
`define SPD_SLOT_HIGH 3'h0
`define SPD_SLOT_MID 3'h1
`define SPD_SLOT_LOW 3'h2
`define SPD_SLOT_S4 3'h3
`define SPD_SLOT_S5 3'h4
`define SPD_SLOT_S6 3'h5
`define SPD_SLOT_S7 3'h6

// Frequencies in 0.1 Hz, times in 0.1 s
`define SPD_RST_HIGH 16'h0258
`define SPD_RST_MID 16'h012C
`define SPD_RST_LOW 16'h0064
`define SPD_NOT_SELECTED 16'h270F
`define SPD_RST_MAXF 16'h04B0
`define SPD_RST_TIME 16'h0032
`define SPD_RST_MODE 2'h0
`define SPD_RST_WPROT 2'h0
`define SPD_WPROT_RUN_OK 2'h2

// Status field positions
`define SPD_ST_MODE_LSB 16
`define SPD_ST_SECOND 18
`define SPD_ST_NV_PEND 19
`define SPD_ST_JOG 20

// Timing
`define SPD_CLK_HZ 20000000
`define SPD_TIME_UNITS_PER_S 10
`define SPD_REF_UNITS 600
`define SPD_RAMP_TICK_CYC (`SPD_CLK_HZ / `SPD_TIME_UNITS_PER_S / `SPD_REF_UNITS)
`define SPD_SAVE_PERIOD_S 60

`endif

// [rtl/spd_pkg.sv]
// Types shared by the speed setter files
package spd_pkg;
    typedef logic [15:0] spd_freq_t;
    typedef logic [2:0] spd_slot_t;
    typedef enum logic [2:0] {
        SPD_BUS_IDLE = 3'b001,
        SPD_BUS_WAIT = 3'b010,
        SPD_BUS_ACK = 3'b100
    } spd_bus_st_t;
    typedef enum logic [1:0] {
        SPD_MODE_PRESET = 2'h0,
        SPD_MODE_REM_STORE = 2'h1,
        SPD_MODE_REM_NOSTORE = 2'h2,
        SPD_MODE_REM_STARTCLR = 2'h3
    } spd_mode_t;
endpackage

// [rtl/spd_preset_mem.sv]
// Seven preset frequencies, one write port and two registered read ports
`timescale 1ns/1ps
`include "spd_consts.svh"
module spd_preset_mem (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic wr_en, // Write strobe
    input wire spd_pkg::spd_slot_t wr_slot, // Write slot
    input wire spd_pkg::spd_freq_t wr_data, // Write data
    input wire spd_pkg::spd_slot_t rd_a_slot, // Read slot A
    input wire spd_pkg::spd_slot_t rd_b_slot, // Read slot B
    output spd_pkg::spd_freq_t rd_a_data, // Registered data A
    output spd_pkg::spd_freq_t rd_b_data // Registered data B
);
    import spd_pkg::*;

    function automatic spd_freq_t reset_value(input int slot);
        case (slot)
            0: reset_value = `SPD_RST_HIGH;
            1: reset_value = `SPD_RST_MID;
            2: reset_value = `SPD_RST_LOW;
            default: reset_value = `SPD_NOT_SELECTED;
        endcase
    endfunction

    spd_freq_t mem_q [7];

    generate
        for (genvar i = 0; i < 7; i++) begin : g_word
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_q[i] <= reset_value(i);
                end else if (wr_en && wr_slot == 3'(i)) begin
                    mem_q[i] <= wr_data;
                end
            end
        end
    endgenerate

    // Slot 7 does not exist and reads as zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_a_data <= 16'h0000;
            rd_b_data <= 16'h0000;
        end else begin
            rd_a_data <= (rd_a_slot == 3'h7) ? 16'h0000 : mem_q[rd_a_slot];
            rd_b_data <= (rd_b_slot == 3'h7) ? 16'h0000 : mem_q[rd_b_slot];
        end
    end
endmodule // spd_preset_mem

// [tb/spd_store_model.sv]
// Nonvolatile store stand-in: restore value and write acknowledge
`timescale 1ns/1ps
module spd_store_model #(
    parameter logic [15:0] RESTORE = 16'h0002
) (
    input wire logic clk, // Clock
    input wire logic nv_wr_req, // Store request
    output spd_pkg::spd_freq_t nv_restore_data, // Stored amount
    output logic nv_wr_ack = 1'b0 // Store done pulse
);
    import spd_pkg::*;
    int wait_n = 0;
    logic slow = 1'b0;
    assign nv_restore_data = RESTORE;
    // Alternate prompt and slow answers; a real store takes long
    always @(posedge clk) begin
        nv_wr_ack <= 1'b0;
        if (nv_wr_req && !nv_wr_ack) begin
            wait_n <= wait_n + 1;
            if (wait_n >= (slow ? 12 : 1)) begin
                nv_wr_ack <= 1'b1;
                wait_n <= 0;
                slow <= !slow;
            end
        end
    end
endmodule // spd_store_model

// [tb/spd_setter_checker.sv]
// Concurrent checks on the speed setter ports
`timescale 1ns/1ps
module spd_setter_checker (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic avs_read, // In
    input wire logic avs_write, // In
    input wire logic avs_waitrequest, // Out
    input wire logic high_select_or_up_input, // In
    input wire logic middle_select_or_down_input, // In
    input wire logic low_select_or_clear_input, // In
    input wire logic forward_start_input, // In
    input wire logic reverse_start_input, // In
    input wire logic second_function_select, // In
    input wire logic jog_active, // In
    input wire logic local_operator_panel, // In
    input wire spd_pkg::spd_freq_t network_freq, // In
    input wire spd_pkg::spd_freq_t panel_freq, // In
    input wire logic nv_wr_ack, // In
    input wire logic nv_wr_req, // Out
    input wire spd_pkg::spd_freq_t nv_wr_data, // Out
    input wire spd_pkg::spd_freq_t freq_cmd, // Out
    input wire logic remote_active, // Out
    input wire logic second_set_active // Out
);
    import spd_pkg::*;
    logic [32:0] base_q;
    logic same;
    logic idle;
    logic [15:0] base;
    // Last cycle's base, so a held base can be told from a moving one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_q <= '0;
        end else begin
            base_q <= {local_operator_panel, network_freq, panel_freq};
        end
    end
    assign same = !avs_write &&
        base_q == {local_operator_panel, network_freq, panel_freq};
    assign idle = !high_select_or_up_input && !middle_select_or_down_input
        && !low_select_or_clear_input && !forward_start_input
        && !reverse_start_input;
    assign base = local_operator_panel ? panel_freq : network_freq;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_bus_answer;
        $rose(avs_read || avs_write) |->
            avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer late or early");
    property p_floor;
        remote_active && $past(remote_active) && same |-> freq_cmd >= base;
    endproperty
    a_floor: assert property (p_floor)
        else $error("command below base");
    property p_jog;
        (remote_active && jog_active && same) [*2] |=> $stable(freq_cmd);
    endproperty
    a_jog: assert property (p_jog)
        else $error("command moved during jog");
    property p_stop;
        (remote_active && idle && same) [*8] |=> $stable(freq_cmd);
    endproperty
    a_stop: assert property (p_stop)
        else $error("command moved with inputs released");
    property p_second;
        second_function_select [*6] |=> second_set_active;
    endproperty
    a_second: assert property (p_second)
        else $error("alternate set not selected");
    property p_req_hold;
        nv_wr_req && !nv_wr_ack |=> nv_wr_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("store request dropped early");
    property p_req_data;
        nv_wr_req && $past(nv_wr_req) && !$past(nv_wr_ack) |->
            $stable(nv_wr_data);
    endproperty
    a_req_data: assert property (p_req_data)
        else $error("store data changed");
    property p_base;
        (!remote_active && idle && same) [*8] |=> freq_cmd == base;
    endproperty
    a_base: assert property (p_base)
        else $error("command is not the base");
    c_store: cover property (nv_wr_req && nv_wr_ack);
    c_jog: cover property (remote_active && jog_active);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule // spd_setter_checker
bind spd_setter spd_setter_checker i_spd_setter_checker (.*);

// [tb/spd_setter_test.sv]
// Self-checking bench of the speed setter with a store stand-in
`timescale 1ns/1ps
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
end
module spd_setter_test;
    import spd_pkg::*;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, req_q = 0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, exp_v, exp_q[$];
    logic avs_waitrequest, nv_wr_ack, nv_wr_req;
    logic high_select_or_up_input = 0, middle_select_or_down_input = 0;
    logic low_select_or_clear_input = 0, forward_start_input = 0;
    logic reverse_start_input = 0, second_function_select = 0;
    logic aux_supply_input = 0, jog_active = 0, local_operator_panel = 0;
    logic remote_active, second_set_active;
    spd_freq_t network_freq = '0, panel_freq = '0, nv_restore_data;
    spd_freq_t nv_wr_data, freq_cmd;
    int n_errors = 0, num_checks = 0, cyc = 0, seed = 32'h0a97;
    // Short minute so the periodic save stays reachable in simulation
    spd_setter #(.MINUTE_CYC(200)) i_spd_setter (.*);
    spd_store_model i_spd_store_model (.*);
    always #25 clk = !clk;
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            conclude();
        end
    end
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            exp_v = exp_q.pop_front();
            `CHK(avs_readdata, exp_v)
        end
        if (nv_wr_req === 1'b1 && !req_q) begin
            exp_v = exp_q.pop_front();
            `CHK({16'h0000, nv_wr_data}, exp_v)
        end
        req_q <= nv_wr_req;
    end
    // Called just after a rising edge; returns just after one
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 40) n_errors++;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pins(input logic [2:0] s);
        high_select_or_up_input <= s[2];
        middle_select_or_down_input <= s[1];
        low_select_or_clear_input <= s[0];
        second_function_select <= 1'($random(seed));
        repeat (10) @(posedge clk);
    endtask
    function automatic logic [31:0] pexp(input logic [2:0] s);
        if (s == 3'b101) return 32'h0000_0123;
        if (s[0]) return 32'h0000_0064;
        if (s[1]) return 32'h0000_012C;
        if (s[2]) return 32'h0000_0258;
        return {16'h0000, local_operator_panel ? panel_freq : network_freq};
    endfunction
    function automatic logic [31:0] st(input logic [1:0] m,
            input logic [15:0] a);
        return {13'h0000, second_function_select, m, a};
    endfunction
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        network_freq <= 16'({$random(seed)} % 1000);
        panel_freq <= 16'({$random(seed)} % 1000);
        repeat (10) @(posedge clk);
        rd(4'h0, 32'h0000_0258);
        rd(4'h1, 32'h0000_012C);
        rd(4'h2, 32'h0000_0064);
        rd(4'h3, 32'h0000_270F);
        rd(4'h7, 32'h0000_0000);
        forward_start_input <= 1'b1;
        bus(1'b1, 4'h4, 32'h0000_0123);
        for (int i = 0; i < 16; i++) begin
            local_operator_panel <= i[3];
            pins(i[2:0]);
            rd(4'hF, pexp(i[2:0]));
        end
        forward_start_input <= 1'b0;
        pins(3'b000);
        bus(1'b1, 4'h8, 32'h0000_0000);
        bus(1'b1, 4'hA, 32'h0000_0000);
        bus(1'b1, 4'hC, 32'h0000_0003);
        bus(1'b1, 4'h7, 32'h0000_0002);
        pins(3'b001);
        rd(4'hF, pexp(3'b000));
        pins(3'b100);
        repeat (20000) @(posedge clk);
        pins(3'b000);
        rd(4'hF, pexp(3'b000) + 3);
        rd(4'hE, st(2'h2, 16'h0003));
        local_operator_panel <= 1'b1;
        jog_active <= 1'b1;
        pins(3'b001);
        rd(4'hF, pexp(3'b000) + 3);
        jog_active <= 1'b0;
        pins(3'b001);
        rd(4'hF, pexp(3'b000));
        pins(3'b000);
        bus(1'b1, 4'h7, 32'h0000_0001);
        rd(4'hE, st(2'h1, 16'h0002));
        pins(3'b100);
        repeat (20000) @(posedge clk);
        forward_start_input <= 1'b1;
        pins(3'b000);
        exp_q.push_back(32'h0000_0003);
        aux_supply_input <= 1'b1;
        repeat (40) @(posedge clk);
        exp_q.push_back(32'h0000_0003);
        forward_start_input <= 1'b0;
        repeat (40) @(posedge clk);
        aux_supply_input <= 1'b0;
        // Clear alone stores nothing; the armed minute check stores it
        pins(3'b001);
        exp_q.push_back(32'h0000_0000);
        pins(3'b110);
        repeat (300) @(posedge clk);
        bus(1'b1, 4'h7, 32'h0000_0003);
        pins(3'b100);
        repeat (4000) @(posedge clk);
        reverse_start_input <= 1'b1;
        pins(3'b000);
        rd(4'hE, st(2'h3, 16'h0001));
        reverse_start_input <= 1'b0;
        pins(3'b000);
        rd(4'hE, st(2'h3, 16'h0000));
        conclude();
    end
endmodule // spd_setter_test
